// file: hw/sit_scheduled_timer.sv
// scheduled interrupt timer: control instruction decode, bcd countdown and subroutine service
// Operation
// - instruction acts only when selector is 004, other selectors are errors
// - code 000 loads data as new repeat interval
// - code 001 loads data as delay to first interrupt
// - code 002 returns active repeat interval, timer untouched
// - times are four bcd digits, hundredths of a second, 00.01 to 99.99
// - repeat interval of zero cancels further periodic interrupts
// - new repeat interval accepted at any time while running
// - new repeat interval takes effect only after the next interrupt, or at once while the timer is stopped
// - first delay of zero raises no interrupt
// - code 001 restarts timing at once, changing spacing for one period
// - every first-delay rewrite restarts the countdown
// - subroutine not invoked until times programmed by the instruction
// - firing moment depends only on programmed timing, not scan cycle
// - after the subroutine, execution resumes exactly where main program stopped
// - bad function code, selector or operand sets error and skips instruction
// - bad indirect word (missing, non-bcd, out of bounds) sets error
// - scheduled interrupt always invokes subroutine 99
`timescale 1ns/1ps
module sit_scheduled_timer #(
  parameter int unsigned TICK_CYCLES = sit_pkg::TICK_CYCLES
) (
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  input  wire logic              cmd_valid_i,
  input  wire sit_pkg::sit_cmd_t cmd_i,
  input  wire logic              insn_boundary_i,
  input  wire logic [15:0]       pc_i,
  input  wire logic              sub_ret_i,
  output logic                   error_flag_o,
  output logic                   rd_valid_o,
  output logic [15:0]            rd_data_o,
  output logic                   sub_start_o,
  output logic [7:0]             sub_num_o,
  output logic                   resume_o,
  output logic [15:0]            resume_addr_o,
  output logic                   in_sub_o
);

  localparam int unsigned TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  localparam logic [TW-1:0] TICK_ZERO = TW'(0);

  // true when every nibble is a decimal digit
  function automatic logic sit_is_bcd(input logic [15:0] v);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (v[4*i +: 4] > 4'h9) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // subtract one from a four-digit bcd value
  function automatic logic [15:0] sit_bcd_dec(input logic [15:0] v);
    logic [15:0] r;
    logic        b;
    r = v;
    b = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (b) begin
        if (r[4*i +: 4] == 4'h0) begin
          r[4*i +: 4] = 4'h9;
        end else begin
          r[4*i +: 4] = r[4*i +: 4] - 4'h1;
          b = 1'b0;
        end
      end
    end
    return r;
  endfunction

  logic [TW-1:0]     tick_cnt_r;
  logic [15:0]       countdown_r;
  logic [15:0]       interval_r;
  logic [15:0]       pend_interval_r;
  logic              running_r;
  logic              int_set_r;
  logic              delay_set_r;
  sit_pkg::sit_srv_t srv_r;
  sit_pkg::sit_srv_t srv_nxt;
  logic [15:0]       resume_addr_r;
  logic              error_r;
  logic              rd_valid_r;
  logic [15:0]       rd_data_r;
  logic              sub_start_r;
  logic              resume_r;

  // instruction checks
  wire fc_set_int  = cmd_i.function_code == sit_pkg::FC_SET_INTERVAL;
  wire fc_set_1st  = cmd_i.function_code == sit_pkg::FC_SET_FIRST;
  wire fc_read     = cmd_i.function_code == sit_pkg::FC_READ_INTERVAL;
  wire fc_ok       = fc_set_int | fc_set_1st | fc_read;
  wire sel_ok      = cmd_i.selector == sit_pkg::SEL_SCHEDULED;
  wire const_ok    = !(cmd_i.data_is_const && fc_read);
  wire time_ok     = fc_read || sit_is_bcd(cmd_i.data);
  wire ind_ok      = !cmd_i.indirect ||
                     (cmd_i.ind_exists && cmd_i.ind_in_bounds && sit_is_bcd(cmd_i.data));
  wire cmd_ok      = fc_ok && sel_ok && const_ok && time_ok && ind_ok;
  wire do_set_int  = cmd_valid_i && cmd_ok && fc_set_int;
  wire do_set_1st  = cmd_valid_i && cmd_ok && fc_set_1st;
  wire do_read     = cmd_valid_i && cmd_ok && fc_read;

  // tick and expiry; the countdown runs on its own timebase, never on the scan
  wire tick        = tick_cnt_r == TICK_LAST;
  wire expire      = tick && running_r && countdown_r == sit_pkg::BCD_ONE;
  wire fire        = expire && int_set_r && delay_set_r;
  // a write landing on the expiry cycle is the value the next period uses, so count and readback agree
  wire [15:0] reload_val = do_set_int ? cmd_i.data : pend_interval_r;
  wire reload_zero = reload_val == sit_pkg::BCD_ZERO;

  // tick prescaler, realigned on a first-delay write so the new delay is exact
  always_ff @(posedge core_clk_i) begin
    if (rst_i || do_set_1st || tick) begin
      tick_cnt_r <= TICK_ZERO;
    end else begin
      tick_cnt_r <= tick_cnt_r + TW'(1);
    end
  end

  // countdown and run state; a first-delay write beats an expiry in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      countdown_r <= sit_pkg::BCD_ZERO;
      running_r   <= 1'b0;
    end else if (do_set_1st) begin
      countdown_r <= cmd_i.data;
      running_r   <= cmd_i.data != sit_pkg::BCD_ZERO;
    end else if (expire) begin
      countdown_r <= reload_val;
      running_r   <= !reload_zero;
    end else if (tick && running_r) begin
      countdown_r <= sit_bcd_dec(countdown_r);
    end
  end

  // repeat interval: written value waits while running, active value swaps at expiry
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pend_interval_r <= sit_pkg::BCD_ZERO;
      interval_r      <= sit_pkg::BCD_ZERO;
    end else begin
      if (do_set_int) begin
        pend_interval_r <= cmd_i.data;
      end
      if (expire) begin
        interval_r <= reload_val;
      end else if (do_set_int && !running_r) begin
        interval_r <= cmd_i.data;                          // nothing timed yet, apply now
      end
    end
  end

  // programmed-by-instruction flags; a missing first delay means no firing at all
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      int_set_r   <= 1'b0;
      delay_set_r <= 1'b0;
    end else begin
      int_set_r   <= int_set_r | do_set_int;
      delay_set_r <= delay_set_r | do_set_1st;
    end
  end

  // instruction result: error per instruction, read answer one cycle later
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      error_r    <= 1'b0;
      rd_valid_r <= 1'b0;
      rd_data_r  <= sit_pkg::BCD_ZERO;
    end else begin
      if (cmd_valid_i) begin
        error_r <= !cmd_ok;
      end
      rd_valid_r <= do_read;
      if (do_read) begin
        rd_data_r <= interval_r;
      end
    end
  end

  // service sequencer: a pending fire is entered only at an instruction boundary
  always_comb begin
    srv_nxt = srv_r;
    case (srv_r)
      sit_pkg::SRV_IDLE: begin
        if (fire) begin
          srv_nxt = sit_pkg::SRV_PEND;
        end
      end
      sit_pkg::SRV_PEND: begin
        if (insn_boundary_i) begin
          srv_nxt = sit_pkg::SRV_INSUB;
        end
      end
      sit_pkg::SRV_INSUB: begin
        if (sub_ret_i) begin
          srv_nxt = fire ? sit_pkg::SRV_PEND : sit_pkg::SRV_IDLE;
        end
      end
      default: begin
        srv_nxt = sit_pkg::SRV_IDLE;
      end
    endcase
  end

  wire enter_sub = srv_r == sit_pkg::SRV_PEND && insn_boundary_i;
  wire leave_sub = srv_r == sit_pkg::SRV_INSUB && sub_ret_i;

  // fires that land while already pending merge into one entry, overruns are not queued
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      srv_r         <= sit_pkg::SRV_IDLE;
      resume_addr_r <= sit_pkg::RESUME_RST;
      sub_start_r   <= 1'b0;
      resume_r      <= 1'b0;
    end else begin
      srv_r       <= srv_nxt;
      sub_start_r <= enter_sub;
      resume_r    <= leave_sub;
      if (enter_sub) begin
        resume_addr_r <= pc_i;
      end
    end
  end

  assign error_flag_o  = error_r;
  assign rd_valid_o    = rd_valid_r;
  assign rd_data_o     = rd_data_r;
  assign sub_start_o   = sub_start_r;
  assign sub_num_o     = sit_pkg::SUB_SCHEDULED;
  assign resume_o      = resume_r;
  assign resume_addr_o = resume_addr_r;
  assign in_sub_o      = srv_r == sit_pkg::SRV_INSUB;

  property p_sel_err;
    @(posedge core_clk_i) disable iff (rst_i)
    cmd_valid_i && !sel_ok |=> error_flag_o;
  endproperty
  a_sel_err: assert property (p_sel_err) else $error("bad selector not flagged");

  property p_err_no_exec;
    @(posedge core_clk_i) disable iff (rst_i)
    cmd_valid_i && !cmd_ok && !expire && !tick |=> $stable(countdown_r) && $stable(pend_interval_r) && !rd_valid_o;
  endproperty
  a_err_no_exec: assert property (p_err_no_exec) else $error("erroneous instruction executed");

  property p_load_first;
    @(posedge core_clk_i) disable iff (rst_i)
    do_set_1st |=> countdown_r == $past(cmd_i.data) && tick_cnt_r == TICK_ZERO;
  endproperty
  a_load_first: assert property (p_load_first) else $error("first delay not loaded");

  property p_zero_first;
    @(posedge core_clk_i) disable iff (rst_i)
    do_set_1st && cmd_i.data == sit_pkg::BCD_ZERO |=> !running_r;
  endproperty
  a_zero_first: assert property (p_zero_first) else $error("zero first delay still running");

  property p_read;
    @(posedge core_clk_i) disable iff (rst_i)
    do_read |=> rd_valid_o && rd_data_o == $past(interval_r);
  endproperty
  a_read: assert property (p_read) else $error("read interval wrong");

  property p_defer;
    @(posedge core_clk_i) disable iff (rst_i)
    do_set_int && running_r && !expire |=> $stable(interval_r);
  endproperty
  a_defer: assert property (p_defer) else $error("interval applied before expiry");

  property p_programmed;
    @(posedge core_clk_i) disable iff (rst_i)
    sub_start_o |-> int_set_r && delay_set_r;
  endproperty
  a_programmed: assert property (p_programmed) else $error("subroutine started unprogrammed");

  property p_resume;
    @(posedge core_clk_i) disable iff (rst_i)
    enter_sub ##1 (in_sub_o && !sub_ret_i)[*1] ##1 sub_ret_i |=> resume_o && resume_addr_o == $past(pc_i, 3);
  endproperty
  a_resume: assert property (p_resume) else $error("resume address lost");

  property p_sub99;
    @(posedge core_clk_i) disable iff (rst_i)
    sub_start_o |-> sub_num_o == 8'h99 && $past(srv_r) == sit_pkg::SRV_PEND;
  endproperty
  a_sub99: assert property (p_sub99) else $error("wrong subroutine number");

  property p_tick_dec;
    @(posedge core_clk_i) disable iff (rst_i)
    tick && running_r && !expire && !do_set_1st |=> countdown_r == sit_bcd_dec($past(countdown_r));
  endproperty
  a_tick_dec: assert property (p_tick_dec) else $error("countdown step wrong");

  property p_cancel;
    @(posedge core_clk_i) disable iff (rst_i)
    expire && reload_zero && !do_set_1st |=> !running_r ##1 !fire;
  endproperty
  a_cancel: assert property (p_cancel) else $error("zero interval did not cancel");

endmodule

// file: include/sit_pkg.sv
// shared constants and types of the scheduled interrupt timer
package sit_pkg;

  // function codes, three bcd digits
  localparam logic [11:0] FC_SET_INTERVAL = 12'h000;
  localparam logic [11:0] FC_SET_FIRST    = 12'h001;
  localparam logic [11:0] FC_READ_INTERVAL = 12'h002;
  // the only target selector served here
  localparam logic [11:0] SEL_SCHEDULED   = 12'h004;
  // subroutine number invoked by the scheduler, bcd
  localparam logic [7:0]  SUB_SCHEDULED   = 8'h99;

  // reset values and the expiry count
  localparam logic [15:0] BCD_ZERO        = 16'h0000;
  localparam logic [15:0] BCD_ONE         = 16'h0001;
  localparam logic [15:0] RESUME_RST      = 16'h0000;

  // timing: one countdown step per hundredth of a second
  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam int unsigned TICK_MS         = 10;
  localparam int unsigned TICK_CYCLES     = (TICK_MS * 1000000) / CLK_PERIOD_NS;

  // one control instruction as presented by the processor
  typedef struct packed {
    logic [11:0] function_code; // bcd function code
    logic [11:0] selector;      // target selector
    logic [15:0] data;          // data operand value (constant or word content)
    logic        data_is_const; // operand given as immediate constant
    logic        indirect;      // operand reached through an indirect data_memory_area word
    logic        ind_exists;    // indirect word exists
    logic        ind_in_bounds; // indirect index stays inside the data_memory_area
  } sit_cmd_t;

  // service sequencer states, one-hot
  typedef enum logic [2:0] {
    SRV_IDLE  = 3'b001,
    SRV_PEND  = 3'b010,
    SRV_INSUB = 3'b100
  } sit_srv_t;

endpackage

// file: sim/sit_tb.sv
// self-checking bench of the scheduled interrupt timer
`timescale 1ns/1ps
module tb;
  localparam int unsigned TK = 8;
  logic              core_clk_i;
  logic              rst_i;
  logic              cmd_valid_i;
  sit_pkg::sit_cmd_t cmd_i;
  logic              insn_boundary_i;
  logic [15:0]       pc_i;
  logic              sub_ret_i;
  logic              error_flag_o;
  logic              rd_valid_o;
  logic [15:0]       rd_data_o;
  logic              sub_start_o;
  logic [7:0]        sub_num_o;
  logic              resume_o;
  logic [15:0]       resume_addr_o;
  logic              in_sub_o;
  int                fail_count = 0;
  int                checks = 0;
  int                seed = 59914;
  int                cyc = 0;
  int                c0;
  int                c1;
  int                e_cyc;
  logic              v_prev = 1'b0;
  logic              v_now;
  logic [15:0]       rnd;
  logic              err_q[$];
  logic [15:0]       rd_q[$];
  logic [15:0]       pc_q[$];
  int                st_q[$];

  // short tick so that whole periods fit in a quick run
  sit_scheduled_timer #(.TICK_CYCLES(TK)) u_dut (
    .core_clk_i      (core_clk_i),
    .rst_i           (rst_i),
    .cmd_valid_i     (cmd_valid_i),
    .cmd_i           (cmd_i),
    .insn_boundary_i (insn_boundary_i),
    .pc_i            (pc_i),
    .sub_ret_i       (sub_ret_i),
    .error_flag_o    (error_flag_o),
    .rd_valid_o      (rd_valid_o),
    .rd_data_o       (rd_data_o),
    .sub_start_o     (sub_start_o),
    .sub_num_o       (sub_num_o),
    .resume_o        (resume_o),
    .resume_addr_o   (resume_addr_o),
    .in_sub_o        (in_sub_o)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    if (fail_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // one instruction; the expected flag is noted before it goes out
  task automatic issue(input logic [11:0] fc, input logic [11:0] sel, input logic [15:0] d, input logic [3:0] fl,
                       input logic e);
    @(posedge core_clk_i);
    #1;
    cmd_valid_i = 1'b1;
    cmd_i = {fc, sel, d, fl};
    err_q.push_back(e);
    @(posedge core_clk_i);
    #1;
    c0 = cyc;
    cmd_valid_i = 1'b0;
  endtask

  task automatic rd(input logic [15:0] v);
    rd_q.push_back(v);
    issue(12'h002, 12'h004, 16'h0000, 4'b0000, 1'b0);
  endtask

  // stepping off the edge keeps the cycle count read free of a race with the watcher
  task automatic wait_to(input int c);
    while (cyc < c) begin
      @(posedge core_clk_i);
      #1;
    end
  endtask

  // bounded wait for every expected start, resume and read entry to have shown up
  task automatic drain();
    int n;
    n = 0;
    while ((st_q.size() != 0 || pc_q.size() != 0 || rd_q.size() != 0) && n < 2000) begin
      @(posedge core_clk_i);
      n++;
    end
    if (st_q.size() != 0 || pc_q.size() != 0 || rd_q.size() != 0) begin
      fail_count++;
      summarize();
    end
  endtask

  // watcher: each result takes the oldest note of its kind
  always @(posedge core_clk_i) begin
    cyc++;
    v_now = cmd_valid_i;
    #2;
    if (v_prev === 1'b1) check("error_flag", error_flag_o, err_q.pop_front());
    v_prev = v_now;
    if (rd_valid_o === 1'b1) check("rd_data", rd_data_o, rd_q.size() > 0 ? rd_q.pop_front() : 'x);
    if (sub_start_o === 1'b1) begin
      // unexpected entries get an impossible cycle, so they always mismatch
      e_cyc = (st_q.size() > 0) ? st_q.pop_front() : -100;
      check("fire_cycle", (cyc >= e_cyc - 2 && cyc <= e_cyc + 2) ? e_cyc : cyc, e_cyc);
      check("sub_num", sub_num_o, 8'h99);
      check("in_sub", in_sub_o, 1'b1);
    end
    if (resume_o === 1'b1) begin
      check("resume_addr", resume_addr_o, pc_q.size() > 0 ? pc_q.pop_front() : 'x);
      check("in_sub", in_sub_o, 1'b0);
    end
  end

  // main program side: return one cycle after entry, move on after resume;
  // boundaries only every other cycle, so some entries wait while pending
  always @(posedge core_clk_i) begin
    #1;
    sub_ret_i = (sub_start_o === 1'b1);
    insn_boundary_i = ~insn_boundary_i;
    if (sub_start_o === 1'b1) pc_q.push_back(pc_i);
    if (resume_o === 1'b1) pc_i = 16'($random(seed));
  end

  initial begin
    rst_i = 1'b1;
    cmd_valid_i = 1'b0;
    cmd_i = '0;
    insn_boundary_i = 1'b1;
    pc_i = 16'($random(seed));
    sub_ret_i = 1'b0;
    repeat (8) @(posedge core_clk_i);
    #1;
    rst_i = 1'b0;
    check("rst_outputs", {error_flag_o, rd_valid_o, sub_start_o, resume_o, in_sub_o, sub_num_o}, {5'h00, 8'h99});
    // refused instructions, one idle cycle apart
    issue(12'h003, 12'h004, 16'h0001, 4'b1000, 1'b1);
    issue(12'h000, 12'h005, 16'h0001, 4'b1000, 1'b1);
    issue(12'h002, 12'h004, 16'h0000, 4'b1000, 1'b1);
    issue(12'h000, 12'h004, 16'h00a1, 4'b1000, 1'b1);
    issue(12'h001, 12'h004, 16'h0001, 4'b0110, 1'b1);
    issue(12'h001, 12'h004, 16'h0001, 4'b0101, 1'b1);
    issue(12'h000, 12'h004, 16'h0a01, 4'b0111, 1'b1);
    rd(16'h0000);
    // first delay alone must not start the subroutine
    issue(12'h001, 12'h004, 16'h0001, 4'b1000, 1'b0);
    wait_to(c0 + 4 * TK);
    for (int k = 0; k < 3; k++) begin
      rnd = 16'h0000;
      for (int j = 0; j < 4; j++) rnd = {rnd[11:0], 4'($unsigned($random(seed)) % 10)};
      issue(12'h000, 12'h004, rnd, 4'b1000, 1'b0);
      rd(rnd);
    end
    // periodic run, interval change mid-period, then cancel
    issue(12'h000, 12'h004, 16'h0002, 4'b1000, 1'b0);
    issue(12'h001, 12'h004, 16'h0003, 4'b1000, 1'b0);
    c1 = c0;
    st_q.push_back(c1 + 3 * TK + 3);
    st_q.push_back(c1 + 5 * TK + 3);
    st_q.push_back(c1 + 10 * TK + 3);
    wait_to(c1 + 4 * TK);
    issue(12'h000, 12'h004, 16'h0005, 4'b1000, 1'b0);
    rd(16'h0002);
    wait_to(c1 + 6 * TK);
    rd(16'h0005);
    wait_to(c1 + 7 * TK);
    issue(12'h000, 12'h004, 16'h0000, 4'b1000, 1'b0);
    wait_to(c1 + 14 * TK);
    drain();
    // rewrites before expiry hold the interrupt off
    issue(12'h000, 12'h004, 16'h0003, 4'b1000, 1'b0);
    for (int k = 0; k < 3; k++) begin
      issue(12'h001, 12'h004, 16'h0002, 4'b1000, 1'b0);
      wait_to(c0 + TK);
    end
    c1 = c0;
    st_q.push_back(c1 + 2 * TK + 3);
    wait_to(c1 + 3 * TK);
    issue(12'h001, 12'h004, 16'h0001, 4'b1000, 1'b0);
    st_q.push_back(c0 + TK + 3);
    st_q.push_back(c0 + 4 * TK + 3);
    wait_to(c0 + 5 * TK);
    issue(12'h001, 12'h004, 16'h0000, 4'b1000, 1'b0);
    wait_to(c0 + 10 * TK);
    drain();
    summarize();
  end
endmodule
